// ===== rtl/annp_pkg.sv
// holds register offsets, field positions, reset values and carrier types
// of the next-page management registers.
// assumes a 5-bit management register address and 16-bit register data.
package annp_pkg;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [4:0] ANNP_OFF_BASE = 5'h05;
	localparam logic [4:0] ANNP_OFF_EXP = 5'h06;
	localparam logic [4:0] ANNP_OFF_TX = 5'h07;
	localparam logic [4:0] ANNP_OFF_RX = 5'h08;

	////////////////////////////////////////////////////////////////////////
	// expansion status field positions
	localparam int ANNP_B_PLACE_IND = 6;
	localparam int ANNP_B_PLACE_SEL = 5;
	localparam int ANNP_B_PD_FAULT = 4;
	localparam int ANNP_B_PARTNER_NP = 3;
	localparam int ANNP_B_LOCAL_NP = 2;
	localparam int ANNP_B_NEW_PAGE = 1;
	localparam int ANNP_B_PARTNER_AN = 0;

	// next-page word field positions
	localparam int ANNP_B_MORE = 15;
	localparam int ANNP_B_ACK = 14;
	localparam int ANNP_B_MSG = 13;
	localparam int ANNP_B_SECOND_ACKNOWLEDGE_FLAG = 12;
	localparam int ANNP_B_FLIP = 11;
	localparam int ANNP_CODE_W = 11;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [15:0] ANNP_RST_BASE = 16'h0000;
	localparam logic [15:0] ANNP_RST_EXP = 16'h0064;
	localparam logic [15:0] ANNP_RST_TX = 16'h2001;
	localparam logic [15:0] ANNP_RST_RX = 16'h2001;

	////////////////////////////////////////////////////////////////////////
	// carrier types
	typedef struct packed {
		logic more;
		logic ack;
		logic msg;
		logic second_acknowledge_flag;
		logic flip;
		logic [ANNP_CODE_W-1:0] code;
	} annp_page_t;

	typedef struct packed {
		logic [4:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} annp_bus_t;

endpackage

// ===== rtl/annp_lh_bit.sv
// holds one latched-high, clear-on-read status bit.
// assumes set and clr come from logic on the same clock.
`timescale 1ns/10ps

module annp_lh_bit
	import annp_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic set,
	input wire logic clr,
	output logic q
);

	typedef struct packed {
		logic hit;
	} annp_lh_t;

	annp_lh_t st_ff;
	annp_lh_t nxt_st;

	////////////////////////////////////////////////////////////////////////
	// set beats clear so an event in the reading cycle is kept
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.hit = set | (st_ff.hit & ~clr);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign q = st_ff.hit;

	////////////////////////////////////////////////////////////////////////
	set_wins_a: assert property (@(posedge clk) disable iff (!nrst) set |=> q)
		else $error("latched bit lost a set");
	clear_holds_a: assert property (@(posedge clk) disable iff (!nrst) (clr && !set) |=> !q)
		else $error("latched bit not cleared by read");

endmodule

// ===== rtl/annp_regs.sv
// holds the next-page management registers: expansion status, local
// transmit page, partner receive page and partner base abilities.
// assumes the negotiation engine drives its events and words on clk,
// and the register master keeps strobes one cycle long and exclusive.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps

// What this block does
// - bit 6 reads one: place is indicated
// - bit 5 reads one: pages go to 8
// - parallel fault latches high, clears on read
// - bit 3 shows partner next-page ability
// - bit 2 reads one: local next-page able
// - new page received latches, clears on read
// - bit 0 shows partner negotiation ability
// - tx bit 15 advertises more pages
// - tx bit 13 message or unformatted, resets one
// - tx bit 12 sets second acknowledge, reset zero
// - tx flip inverts per page, seeded inverted
// - tx bits 10-0 hold code, reset one
// - rx bit 15 captures partner more pages
// - rx bit 14 captures partner acknowledge
// - rx bit 13 message flag, resets one
// - rx bit 12 captures partner second acknowledge
// - rx flip follows partner, code read-only
// - transmit register content is the sent page
// - each received page stored in rx register
// - base register holds partner base abilities
module annp_regs
	import annp_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input annp_pkg::annp_bus_t bus,
	output logic [15:0] rdata,
	input wire logic pd_fault_evt,
	input wire logic partner_np_able,
	input wire logic partner_an_able,
	input wire logic base_page_evt,
	input wire logic [15:0] base_page_word,
	input wire logic page_rx_evt,
	input annp_pkg::annp_page_t page_rx_word,
	input wire logic neg_start,
	input wire logic local_adv_flip,
	input wire logic tx_page_sent,
	output annp_pkg::annp_page_t tx_page,
	output logic new_page_flag
);

	import annp_pkg::*;

	typedef struct packed {
		logic [15:0] rdata;
		annp_page_t tx;
		annp_page_t rx;
		logic [15:0] base;
	} annp_state_t;

	annp_state_t st_ff;
	annp_state_t nxt_st;
	logic fault_q;
	logic page_q;
	logic exp_rd;
	logic [15:0] exp_word;
	logic [15:0] tx_word;

	////////////////////////////////////////////////////////////////////////
	// latched-high status bits, cleared by a read of the expansion register
	assign exp_rd = bus.rd && (bus.addr == ANNP_OFF_EXP);

	annp_lh_bit u_fault
	(
		.clk(clk),
		.nrst(nrst),
		.set(pd_fault_evt),
		.clr(exp_rd),
		.q(fault_q)
	);

	annp_lh_bit u_page
	(
		.clk(clk),
		.nrst(nrst),
		.set(page_rx_evt),
		.clr(exp_rd),
		.q(page_q)
	);

	////////////////////////////////////////////////////////////////////////
	// expansion status word; fixed ones come from the reset pattern
	always_comb
	begin
		exp_word = ANNP_RST_EXP;
		exp_word[ANNP_B_PD_FAULT] = fault_q;
		exp_word[ANNP_B_PARTNER_NP] = partner_np_able;
		exp_word[ANNP_B_NEW_PAGE] = page_q;
		exp_word[ANNP_B_PARTNER_AN] = partner_an_able;
	end

	// transmit word as read; the acknowledge slot is reserved and reads zero
	always_comb
	begin
		tx_word = st_ff.tx;
		tx_word[ANNP_B_ACK] = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// next state: read data, software writes, engine captures
	always_comb
	begin
		nxt_st = st_ff;
		// read data is zero except in the cycle after a read
		nxt_st.rdata = 16'h0000;
		if (bus.rd)
		begin
			unique case (bus.addr)
				ANNP_OFF_BASE: nxt_st.rdata = st_ff.base;
				ANNP_OFF_EXP: nxt_st.rdata = exp_word;
				ANNP_OFF_TX: nxt_st.rdata = tx_word;
				ANNP_OFF_RX: nxt_st.rdata = st_ff.rx;
				default: nxt_st.rdata = 16'h0000;
			endcase
		end
		// only the writable transmit fields take a write; flip stays hardware-owned
		if (bus.wr && (bus.addr == ANNP_OFF_TX))
		begin
			nxt_st.tx.more = bus.wdata[ANNP_B_MORE];
			nxt_st.tx.msg = bus.wdata[ANNP_B_MSG];
			nxt_st.tx.second_acknowledge_flag = bus.wdata[ANNP_B_SECOND_ACKNOWLEDGE_FLAG];
			nxt_st.tx.code = bus.wdata[ANNP_CODE_W-1:0];
		end
		// flip seeds from the inverted advertisement bit, then inverts per page
		if (neg_start)
			nxt_st.tx.flip = ~local_adv_flip;
		else if (tx_page_sent)
			nxt_st.tx.flip = ~st_ff.tx.flip;
		// base page seeds the partner flip; a next page in the same cycle wins
		if (base_page_evt)
		begin
			nxt_st.base = base_page_word;
			nxt_st.rx.flip = ~base_page_word[ANNP_B_FLIP];
		end
		// pages are stored here since bit 5 of expansion reads one
		if (page_rx_evt)
			nxt_st.rx = page_rx_word;
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_ff.rdata <= 16'h0000;
			st_ff.tx <= ANNP_RST_TX;
			st_ff.rx <= ANNP_RST_RX;
			st_ff.base <= ANNP_RST_BASE;
		end
		else
			st_ff <= nxt_st;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs; the engine inserts its own acknowledge into bit 14
	assign rdata = st_ff.rdata;
	assign tx_page = st_ff.tx;
	assign new_page_flag = page_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	fixed_ones_a: assert property (exp_rd |=> (rdata[6:5] == 2'b11) && rdata[ANNP_B_LOCAL_NP])
		else $error("expansion fixed bits not one");
	reserved_zero_a: assert property (exp_rd |=> (rdata[15:7] == 9'h000))
		else $error("expansion reserved bits not zero");
	fault_read_a: assert property (exp_rd |=> rdata[ANNP_B_PD_FAULT] == $past(fault_q))
		else $error("fault read does not show latch");
	fault_cleared_a: assert property ((exp_rd && fault_q && !pd_fault_evt) |=> !fault_q)
		else $error("fault not cleared by read");
	fault_latch_a: assert property ((pd_fault_evt ##1 !exp_rd) |=> fault_q)
		else $error("fault not held until read");
	partner_np_a: assert property (exp_rd |=> rdata[ANNP_B_PARTNER_NP] == $past(partner_np_able))
		else $error("partner next-page ability wrong");
	partner_an_a: assert property (exp_rd |=> rdata[ANNP_B_PARTNER_AN] == $past(partner_an_able))
		else $error("partner negotiation ability wrong");
	page_latch_a: assert property (page_rx_evt |=> new_page_flag)
		else $error("new page not latched");
	page_read_a: assert property ((exp_rd && page_q) |=> rdata[ANNP_B_NEW_PAGE])
		else $error("clearing read lost page flag");
	tx_write_a: assert property ((bus.wr && bus.addr == ANNP_OFF_TX) |=>
		tx_page.more == $past(bus.wdata[ANNP_B_MORE]) && tx_page.msg == $past(bus.wdata[ANNP_B_MSG])
		&& tx_page.second_acknowledge_flag == $past(bus.wdata[ANNP_B_SECOND_ACKNOWLEDGE_FLAG]) && tx_page.code == $past(bus.wdata[10:0]))
		else $error("transmit write not stored");
	tx_flip_keep_a: assert property ((bus.wr && bus.addr == ANNP_OFF_TX && !neg_start && !tx_page_sent)
		|=> $stable(tx_page.flip))
		else $error("software changed flip bit");
	tx_flip_step_a: assert property ((tx_page_sent && !neg_start) |=> tx_page.flip != $past(tx_page.flip))
		else $error("flip did not invert on page sent");
	tx_flip_seed_a: assert property (neg_start |=> tx_page.flip == !$past(local_adv_flip))
		else $error("flip seed not inverted advertisement");
	rx_store_a: assert property ((page_rx_evt ##1 (bus.rd && bus.addr == ANNP_OFF_RX && !page_rx_evt))
		|=> rdata == $past(page_rx_word, 2))
		else $error("received page not stored");
	rx_seed_a: assert property ((base_page_evt && !page_rx_evt) |=> st_ff.rx.flip == !$past(base_page_word[11]))
		else $error("partner flip seed wrong");
	base_store_a: assert property (base_page_evt |=> st_ff.base == $past(base_page_word))
		else $error("base page not stored");
	idle_zero_a: assert property (!bus.rd |=> rdata == 16'h0000)
		else $error("read data outside read cycle");

	////////////////////////////////////////////////////////////////////////
	// per-field and whole-word checks; each failure message names the bit, field or word it looks at

	// fixed status bits must read one on every expansion read
	place_ind_a: assert property (exp_rd |=> rdata[ANNP_B_PLACE_IND])
		else $error("place indicated bit not one");

	// received pages are routed to the receive register, so this reads one
	place_sel_a: assert property (exp_rd |=> rdata[ANNP_B_PLACE_SEL])
		else $error("place select bit not one");

	// local side always supports next pages
	local_np_a: assert property (exp_rd |=> rdata[ANNP_B_LOCAL_NP])
		else $error("local next-page bit not one");

	// a latched page flag only falls through a read
	page_hold_a: assert property ((new_page_flag && !exp_rd) |=> new_page_flag)
		else $error("page flag dropped without read");

	// a read with no new page in the same cycle clears the flag
	page_clear_a: assert property ((exp_rd && !page_rx_evt) |=> !new_page_flag)
		else $error("page flag not cleared by read");

	// read value of bit 1 is the flag as it stood in the read cycle
	page_match_a: assert property (exp_rd |=> rdata[ANNP_B_NEW_PAGE] == $past(new_page_flag))
		else $error("page flag read mismatch");

	// a fault event always leaves the latch set
	fault_set_a: assert property (pd_fault_evt |=> fault_q)
		else $error("fault event not latched");

	// the fault latch holds until software reads
	fault_hold_a: assert property ((fault_q && !exp_rd) |=> fault_q)
		else $error("fault dropped without read");

	// a read with no fault in the same cycle clears the latch
	fault_clear_a: assert property ((exp_rd && !pd_fault_evt) |=> !fault_q)
		else $error("fault not cleared");

	// the clearing read still shows the latched fault
	fault_shown_a: assert property ((exp_rd && fault_q) |=> rdata[ANNP_B_PD_FAULT])
		else $error("clearing read lost fault");

	// an event inside the clearing read survives it
	fault_race_a: assert property ((exp_rd && pd_fault_evt) |=> fault_q)
		else $error("fault lost in read cycle");

	// same race on the page flag
	page_race_a: assert property ((exp_rd && page_rx_evt) |=> new_page_flag)
		else $error("page lost in read cycle");

	// writable transmit fields move only on a transmit write
	tx_more_keep_a: assert property (!(bus.wr && bus.addr == ANNP_OFF_TX) |=> $stable(tx_page.more))
		else $error("more-pages bit changed");

	tx_msg_keep_a: assert property (!(bus.wr && bus.addr == ANNP_OFF_TX) |=> $stable(tx_page.msg))
		else $error("message bit changed");

	tx_second_acknowledge_flag_keep_a: assert property (!(bus.wr && bus.addr == ANNP_OFF_TX) |=> $stable(tx_page.second_acknowledge_flag))
		else $error("second acknowledge changed");

	tx_code_keep_a: assert property (!(bus.wr && bus.addr == ANNP_OFF_TX) |=> $stable(tx_page.code))
		else $error("transmit code changed");

	// flip moves only on a restart or a sent page
	tx_flip_idle_a: assert property ((!neg_start && !tx_page_sent) |=> $stable(tx_page.flip))
		else $error("flip moved without event");

	// restart and sent page together: the seed wins
	flip_seed_wins_a: assert property ((neg_start && tx_page_sent) |=> tx_page.flip == !$past(local_adv_flip))
		else $error("seed did not win over sent");

	// software reads exactly the page that goes out
	tx_read_a: assert property ((bus.rd && bus.addr == ANNP_OFF_TX) |=> rdata == $past(tx_page))
		else $error("transmit read differs from page");

	// the reserved acknowledge slot never goes out set
	tx_ack_zero_a: assert property ((bus.wr && bus.addr == ANNP_OFF_TX) |=> !tx_page.ack)
		else $error("reserved bit set on page");

	// writes elsewhere leave the outgoing page alone
	tx_other_wr_a: assert property ((bus.wr && bus.addr != ANNP_OFF_TX && !neg_start && !tx_page_sent)
		|=> $stable(tx_page))
		else $error("foreign write changed page");

	// received page fields copied one for one
	rx_more_a: assert property (page_rx_evt |=> st_ff.rx.more == $past(page_rx_word.more))
		else $error("rx more-pages not captured");

	rx_ack_a: assert property (page_rx_evt |=> st_ff.rx.ack == $past(page_rx_word.ack))
		else $error("rx acknowledge not captured");

	rx_msg_a: assert property (page_rx_evt |=> st_ff.rx.msg == $past(page_rx_word.msg))
		else $error("rx message bit not captured");

	rx_second_acknowledge_flag_a: assert property (page_rx_evt |=> st_ff.rx.second_acknowledge_flag == $past(page_rx_word.second_acknowledge_flag))
		else $error("rx second acknowledge not captured");

	rx_flip_a: assert property (page_rx_evt |=> st_ff.rx.flip == $past(page_rx_word.flip))
		else $error("rx flip not captured");

	rx_code_a: assert property (page_rx_evt |=> st_ff.rx.code == $past(page_rx_word.code))
		else $error("rx code not captured");

	// software writes never reach the receive register
	rx_keep_a: assert property ((!page_rx_evt && !base_page_evt) |=> $stable(st_ff.rx))
		else $error("receive register changed");

	// a next page beside a base page is stored whole
	page_wins_a: assert property ((base_page_evt && page_rx_evt) |=> st_ff.rx == $past(page_rx_word))
		else $error("page lost to flip seed");

	// receive read shows the stored page
	rx_read_a: assert property ((bus.rd && bus.addr == ANNP_OFF_RX) |=> rdata == $past(st_ff.rx))
		else $error("receive read mismatch");

	// base abilities move only on a base page
	base_keep_a: assert property (!base_page_evt |=> $stable(st_ff.base))
		else $error("base abilities changed");

	base_read_a: assert property ((bus.rd && bus.addr == ANNP_OFF_BASE) |=> rdata == $past(st_ff.base))
		else $error("base read mismatch");

	// unmapped addresses read zero
	unmapped_a: assert property ((bus.rd && (bus.addr < ANNP_OFF_BASE || bus.addr > ANNP_OFF_RX))
		|=> rdata == 16'h0000)
		else $error("unmapped read not zero");

endmodule

// ===== verif/test_annp_regs.sv
// self-checking bench for the next-page management registers.
// assumes the register bus answers reads one cycle later and engine events are one-cycle pulses.
`timescale 1ns/10ps

module test_annp_regs;
	import annp_pkg::*;

	logic clk = 1'b0;
	logic nrst = 1'b0;
	annp_bus_t bus = '0;
	logic [15:0] rdata;
	logic pd_fault_evt = 1'b0;
	logic partner_np_able = 1'b0;
	logic partner_an_able = 1'b0;
	logic [3:0] ev = 4'h0;
	logic [15:0] base_page_word = 16'h0000;
	annp_page_t page_rx_word = '0;
	logic local_adv_flip = 1'b0;
	annp_page_t tx_page;
	logic new_page_flag;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;
	logic [15:0] row_w [4] = '{16'hFFFF, 16'h0000, 16'h4800, 16'h2001};
	logic [15:0] row_e [4] = '{16'hB7FF, 16'h0000, 16'h0000, 16'h2001};

	// events travel as one vector: base, receive, restart, sent
	annp_regs DUT (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .pd_fault_evt(pd_fault_evt),
		.partner_np_able(partner_np_able), .partner_an_able(partner_an_able), .base_page_evt(ev[3]),
		.base_page_word(base_page_word), .page_rx_evt(ev[2]), .page_rx_word(page_rx_word),
		.neg_start(ev[1]), .local_adv_flip(local_adv_flip), .tx_page_sent(ev[0]),
		.tx_page(tx_page), .new_page_flag(new_page_flag));

	always #20 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	// verdict and run limit; the limit is far above the roughly 80 cycles used
	task end_sim;
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			num_errors++;
			end_sim;
		end
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// bus cycles; p raises a fault event in the read cycle itself
	task wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
		#1;
	endtask

	task rd_chk(input logic [4:0] a, input logic [15:0] e, input logic p);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		pd_fault_evt <= p;
		@(posedge clk);
		bus.rd <= 1'b0;
		pd_fault_evt <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	task pulse(input logic [3:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 4'h0;
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence: reset values, table of transmit writes, then corner cases
	initial
	begin
		repeat (6) @(posedge clk);
		#1;
		chk(tx_page, 16'h2001);
		chk({15'h0, new_page_flag}, 16'h0000);
		nrst <= 1'b1;
		rd_chk(ANNP_OFF_EXP, 16'h0064, 1'b0);
		rd_chk(ANNP_OFF_TX, 16'h2001, 1'b0);
		rd_chk(ANNP_OFF_RX, 16'h2001, 1'b0);
		rd_chk(ANNP_OFF_BASE, 16'h0000, 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(ANNP_OFF_TX, row_w[i]);
			chk(tx_page, row_e[i]);
			rd_chk(ANNP_OFF_TX, row_e[i], 1'b0);
		end
		// read-only places ignore writes and an unmapped address reads zero
		wr_reg(ANNP_OFF_RX, 16'hFFFF);
		wr_reg(ANNP_OFF_EXP, 16'hFFFF);
		rd_chk(ANNP_OFF_RX, 16'h2001, 1'b0);
		rd_chk(ANNP_OFF_EXP, 16'h0064, 1'b0);
		rd_chk(5'h1F, 16'h0000, 1'b0);
		partner_np_able <= 1'b1;
		partner_an_able <= 1'b1;
		rd_chk(ANNP_OFF_EXP, 16'h006D, 1'b0);
		// base page seeds the receive flip with its inverted bit 11
		base_page_word <= 16'h03E1;
		pulse(4'h8);
		rd_chk(ANNP_OFF_BASE, 16'h03E1, 1'b0);
		rd_chk(ANNP_OFF_RX, 16'h2801, 1'b0);
		page_rx_word <= 16'hD9AB;
		pulse(4'h4);
		chk({15'h0, new_page_flag}, 16'h0001);
		rd_chk(ANNP_OFF_RX, 16'hD9AB, 1'b0);
		rd_chk(ANNP_OFF_EXP, 16'h006F, 1'b0);
		rd_chk(ANNP_OFF_EXP, 16'h006D, 1'b0);
		chk({15'h0, new_page_flag}, 16'h0000);
		// a fault arriving during the clearing read must survive it
		rd_chk(ANNP_OFF_EXP, 16'h006D, 1'b1);
		rd_chk(ANNP_OFF_EXP, 16'h007D, 1'b0);
		rd_chk(ANNP_OFF_EXP, 16'h006D, 1'b0);
		pulse(4'h2);
		chk(tx_page, 16'h2801);
		pulse(4'h1);
		rd_chk(ANNP_OFF_TX, 16'h2001, 1'b0);
		wr_reg(ANNP_OFF_TX, 16'h8ABC);
		chk(tx_page, 16'h82BC);
		// a read right behind a stored page must already see it
		page_rx_word <= 16'h35C2;
		@(posedge clk);
		ev <= 4'h4;
		@(posedge clk);
		ev <= 4'h0;
		bus.addr <= ANNP_OFF_RX;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, 16'h35C2);
		// reset in mid-run drops the latched flag and restores defaults
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		#1;
		chk({15'h0, new_page_flag}, 16'h0000);
		chk(tx_page, 16'h2001);
		@(posedge clk);
		nrst <= 1'b1;
		rd_chk(ANNP_OFF_RX, 16'h2001, 1'b0);
		@(posedge clk);
		#1;
		chk(rdata, 16'h0000);
		end_sim;
	end
endmodule
